// *** dv/cplpsc_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cplpsc_defines.svh"

module cplpsc_asserts #(
    parameter int PLL_SETTLE = `CPLPSC_PLL_SETTLE_CLKS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // system to processor
    input wire logic stop_clock_req_n,
    input wire logic sleep_req_n,
    input wire logic deep_sleep_req_n,
    input wire logic cpu_clock_stop_n,
    input wire logic sys_mgmt_irq_n,
    input wire logic snoop_req,
    // processor to system
    input wire logic pending_break_n,
    input wire logic power_status_n,
    input wire logic stop_ack_cycle
);
    // saturating so a long idle never wraps back into a legal window
    logic [7:0] grant_cnt_ff;
    logic [7:0] slp_gap_ff;
    logic [15:0] deep_gap_ff;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    always_ff @(posedge clk_sys) begin
        if (rst || stop_clock_req_n || stop_ack_cycle) begin
            grant_cnt_ff <= 8'h00;
        end else if (grant_cnt_ff != 8'hff) begin
            grant_cnt_ff <= grant_cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            slp_gap_ff <= 8'hff;
        end else if (!sleep_req_n) begin
            slp_gap_ff <= 8'h00;
        end else if (slp_gap_ff != 8'hff) begin
            slp_gap_ff <= slp_gap_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            deep_gap_ff <= 16'hffff;
        end else if (!deep_sleep_req_n) begin
            deep_gap_ff <= 16'h0000;
        end else if (deep_gap_ff != 16'hffff) begin
            deep_gap_ff <= deep_gap_ff + 16'h0001;
        end
    end

    ack_after_stop_a: assert property ($fell(stop_clock_req_n) |-> ##[0:3] stop_ack_cycle)
        else $error("no acknowledge cycle after stop-clock");
    ack_pulse_a: assert property (stop_ack_cycle |=> !stop_ack_cycle)
        else $error("acknowledge cycle longer than one clock");
    grant_delay_a: assert property (!pending_break_n |-> $past(grant_cnt_ff) >= 8'h14)
        else $error("pending break before stop-grant delay");
    break_release_a: assert property ($rose(stop_clock_req_n) |-> ##[1:2] pending_break_n)
        else $error("pending break held after stop-grant exit");
    psi_entry_a: assert property ($fell(deep_sleep_req_n) |-> ##[1:3] !power_status_n)
        else $error("power status not asserted in deep sleep");
    psi_exit_a: assert property ($rose(deep_sleep_req_n) |-> ##[1:3] power_status_n)
        else $error("power status not released after deep sleep");
    psi_cause_a: assert property (!power_status_n |-> !$past(deep_sleep_req_n))
        else $error("power status asserted outside deep sleep");
    clk_stop_pair_a: assert property (cpu_clock_stop_n == deep_sleep_req_n)
        else $error("clock stop and deep sleep requests differ");
    sleep_grant_a: assert property ($fell(sleep_req_n) |-> grant_cnt_ff >= 8'h15)
        else $error("sleep requested outside stop-grant");
    stop_gap_a: assert property ($rose(stop_clock_req_n) |-> slp_gap_ff >= 8'h0a)
        else $error("stop-clock released too soon after sleep");
    settle_wait_a: assert property ($rose(sleep_req_n) |-> int'(deep_gap_ff) >= PLL_SETTLE)
        else $error("sleep released before settling time");
    deep_in_sleep_a: assert property (!deep_sleep_req_n |-> !sleep_req_n)
        else $error("deep sleep requested outside sleep");
    quiet_sleep_a: assert property (!sleep_req_n && !$past(sleep_req_n) |->
        $stable(snoop_req) && $stable(sys_mgmt_irq_n))
        else $error("bus activity during sleep");
endmodule : cplpsc_asserts

`default_nettype wire

// *** dv/cpu_low_power_state_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module cpu_low_power_state_control_bench;
    localparam int SETTLE = 20;
    localparam int WATCHDOG_CYC = 20000;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cpu_rst = 1'b0;
    logic halt_exec = 1'b0;
    logic req_stop = 1'b0;
    logic req_sleep = 1'b0;
    logic req_deep = 1'b0;
    logic in_grant = 1'b0;
    logic [3:0] irq_in = 4'h0;
    logic bus_irq_in = 1'b0;
    logic snoop_in = 1'b0;
    logic snoop_fin = 1'b0;
    logic data_active = 1'b0;
    logic prio_active = 1'b0;
    logic [3:0] irq_service;
    logic in_normal, halted, data_buf_en, addr_buf_en, snoop_active, bclk_stop, seq_busy;
    int mismatches = 0;
    int comparisons = 0;

    always #2 clk_sys = ~clk_sys;

    cplpsc_if u_cplpsc_if();

    // cpu-only reset so the system side keeps stop-clock asserted
    cplpsc_cpu #(.PLL_SETTLE(SETTLE)) u_cplpsc_cpu (
        .clk_sys, .rst(rst | cpu_rst), .lnk(u_cplpsc_if.cpu), .halt_exec, .irq_service,
        .in_normal, .halted, .data_buf_en, .addr_buf_en, .snoop_active
    );

    cplpsc_sys #(.PLL_SETTLE(SETTLE)) u_cplpsc_sys (
        .clk_sys, .rst, .lnk(u_cplpsc_if.sys), .req_stop, .req_sleep, .req_deep, .in_grant,
        .irq_in, .bus_irq_in, .snoop_in, .snoop_fin, .data_active, .prio_active, .bclk_stop,
        .seq_busy
    );

    cplpsc_asserts #(.PLL_SETTLE(SETTLE)) u_cplpsc_asserts (
        .clk_sys, .rst, .stop_clock_req_n(u_cplpsc_if.stop_clock_req_n),
        .sleep_req_n(u_cplpsc_if.sleep_req_n), .deep_sleep_req_n(u_cplpsc_if.deep_sleep_req_n),
        .cpu_clock_stop_n(u_cplpsc_if.cpu_clock_stop_n),
        .sys_mgmt_irq_n(u_cplpsc_if.sys_mgmt_irq_n), .snoop_req(u_cplpsc_if.snoop_req),
        .pending_break_n(u_cplpsc_if.pending_break_n),
        .power_status_n(u_cplpsc_if.power_status_n), .stop_ack_cycle(u_cplpsc_if.stop_ack_cycle)
    );

    function automatic logic sig(input int i);
        case (i)
            0: return u_cplpsc_if.stop_ack_cycle;
            1: return u_cplpsc_if.pending_break_n;
            2: return u_cplpsc_if.power_status_n;
            3: return in_normal;
            4: return halted;
            5: return snoop_active;
            6: return seq_busy;
            7: return data_buf_en;
            8: return addr_buf_en;
            10: return u_cplpsc_if.sleep_req_n;
            default: return bclk_stop;
        endcase
    endfunction : sig

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // always lets one edge pass, so no input is driven twice in a step
    task automatic wait_chk(input int i, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (sig(i) !== v && n < lim);
        chk({7'h0, sig(i)}, {7'h0, v});
    endtask : wait_chk

    task automatic enter_grant();
        req_stop <= 1'b1;
        wait_chk(0, 1'b1, 10);
        cyc(30);
        in_grant <= 1'b1;
    endtask : enter_grant

    task automatic t_buffers();
        wait_chk(7, 1'b0, 2);
        data_active <= 1'b1;
        wait_chk(7, 1'b1, 4);
        data_active <= 1'b0;
        wait_chk(7, 1'b0, 4);
        wait_chk(8, 1'b0, 2);
        prio_active <= 1'b1;
        wait_chk(8, 1'b1, 4);
        prio_active <= 1'b0;
        wait_chk(8, 1'b0, 4);
    endtask : t_buffers

    // every wake source, snoop served once while halted
    task automatic t_halt();
        for (int k = 0; k < 5; k++) begin
            halt_exec <= 1'b1;
            wait_chk(4, 1'b1, 4);
            halt_exec <= 1'b0;
            if (k == 0) begin
                snoop_in <= 1'b1;
                wait_chk(5, 1'b1, 4);
                snoop_in <= 1'b0;
                snoop_fin <= 1'b1;
                wait_chk(5, 1'b0, 4);
                snoop_fin <= 1'b0;
                chk({7'h0, halted}, 8'h01);
            end
            irq_in <= (k < 4) ? 4'h1 << k : 4'h0;
            bus_irq_in <= (k == 4);
            wait_chk(3, 1'b1, 8);
            irq_in <= 4'h0;
            bus_irq_in <= 1'b0;
            cyc(2);
            chk({7'h0, halted}, 8'h00);
        end
    endtask : t_halt

    task automatic t_grant();
        logic [3:0] seen;
        int n;
        seen = 4'h0;
        n = 0;
        enter_grant();
        chk({7'h0, in_normal}, 8'h00);
        irq_in <= 4'ha;
        wait_chk(1, 1'b0, 4);
        irq_in <= 4'h0;
        snoop_in <= 1'b1;
        wait_chk(5, 1'b1, 4);
        snoop_in <= 1'b0;
        snoop_fin <= 1'b1;
        wait_chk(5, 1'b0, 4);
        snoop_fin <= 1'b0;
        cyc(1);
        chk({6'h0, in_normal, u_cplpsc_if.pending_break_n}, 8'h00);
        req_stop <= 1'b0;
        in_grant <= 1'b0;
        repeat (40) begin
            @(posedge clk_sys);
            if (irq_service !== 4'h0) begin
                seen |= irq_service;
                n++;
            end
        end
        chk({4'h0, seen}, 8'h0a);
        chk(n[7:0], 8'h01);
        chk({7'h0, in_normal}, 8'h01);
    endtask : t_grant

    task automatic t_sleep();
        enter_grant();
        req_sleep <= 1'b1;
        cyc(2);
        wait_chk(6, 1'b1, 4);
        snoop_in <= 1'b1;
        irq_in <= 4'h8;
        cyc(3);
        chk({6'h0, snoop_active, in_normal}, 8'h00);
        snoop_in <= 1'b0;
        irq_in <= 4'h0;
        req_deep <= 1'b1;
        wait_chk(2, 1'b0, 10);
        chk({7'h0, u_cplpsc_if.cpu_clock_stop_n}, 8'h00);
        wait_chk(9, 1'b1, 4);
        snoop_in <= 1'b1;
        cyc(2);
        chk({7'h0, snoop_active}, 8'h00);
        snoop_in <= 1'b0;
        req_deep <= 1'b0;
        wait_chk(2, 1'b1, 10);
        chk({7'h0, bclk_stop}, 8'h00);
        req_sleep <= 1'b0;
        cyc(SETTLE - 5);
        chk({7'h0, u_cplpsc_if.sleep_req_n}, 8'h00);
        wait_chk(10, 1'b1, 20);
        chk({7'h0, in_normal}, 8'h00);
        wait_chk(6, 1'b0, 60);
        req_stop <= 1'b0;
        in_grant <= 1'b0;
        wait_chk(3, 1'b1, 60);
    endtask : t_sleep

    task automatic t_rst_grant();
        enter_grant();
        cpu_rst <= 1'b1;
        cyc(1);
        cpu_rst <= 1'b0;
        cyc(1);
        chk({7'h0, in_normal}, 8'h00);
        cyc(4);
        chk({7'h0, in_normal}, 8'h00);
        req_stop <= 1'b0;
        in_grant <= 1'b0;
        wait_chk(3, 1'b1, 40);
    endtask : t_rst_grant

    // full reset in sleep, system drops its requests with it
    task automatic t_rst_sleep();
        enter_grant();
        req_sleep <= 1'b1;
        wait_chk(6, 1'b1, 4);
        cyc(2);
        rst <= 1'b1;
        req_stop <= 1'b0;
        req_sleep <= 1'b0;
        in_grant <= 1'b0;
        cyc(1);
        rst <= 1'b0;
        wait_chk(3, 1'b1, 3);
        chk({7'h0, u_cplpsc_if.stop_ack_cycle}, 8'h00);
    endtask : t_rst_sleep

    task automatic t_halt_stop();
        halt_exec <= 1'b1;
        wait_chk(4, 1'b1, 4);
        halt_exec <= 1'b0;
        enter_grant();
        req_stop <= 1'b0;
        in_grant <= 1'b0;
        cyc(10);
        chk({6'h0, halted, in_normal}, 8'h02);
        irq_in <= 4'h4;
        wait_chk(3, 1'b1, 8);
        irq_in <= 4'h0;
    endtask : t_halt_stop

    initial begin
        cyc(12);
        rst <= 1'b0;
        cyc(2);
        t_buffers();
        t_halt();
        t_grant();
        t_sleep();
        t_rst_grant();
        t_rst_sleep();
        t_halt_stop();
        test_done();
    end

    // a hang counts as one mismatch
    initial begin
        #(WATCHDOG_CYC * 4);
        mismatches++;
        test_done();
    end
endmodule : cpu_low_power_state_control_bench

`default_nettype wire

// *** src/cplpsc_cpu.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cplpsc_defines.svh"

module cplpsc_cpu #(
    parameter int GRANT_DELAY = `CPLPSC_GRANT_DELAY_CLKS,
    parameter int PLL_SETTLE = `CPLPSC_PLL_SETTLE_CLKS,
    parameter int ACK_RESP = `CPLPSC_ACK_RESP_CLKS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // link to system logic
    cplpsc_if.cpu lnk,
    // core side
    input wire logic halt_exec,
    output logic [3:0] irq_service,
    output logic in_normal,
    output logic halted,
    output logic data_buf_en,
    output logic addr_buf_en,
    output logic snoop_active
);
    cplpsc_pkg::cplpsc_state_type state_ff, nxt_state;
    logic halt_ctx_ff, snp_halt_ff;
    logic [3:0] latched_ff;
    logic bus_irq_ff;
    logic pbe_ff, psi_ff, ack_ff;
    logic [3:0] svc_ff;
    logic dbuf_ff, abuf_ff, norm_ff, halted_ff, snoop_ff;
    logic ack_done, grant_done, settle_done, grant_busy;
    logic [3:0] irq_now;
    logic wake_any;

    // smi, init, lint1, lint0
    assign irq_now = {!lnk.sys_mgmt_irq_n, !lnk.init_n, lnk.local_irq_lines};
    assign wake_any = (|irq_now) || lnk.bus_irq_msg;

    // acknowledge response phase, then the fixed grant delay
    cplpsc_delay #(.COUNT(ACK_RESP)) u_ack (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(ack_ff),
        .abort(lnk.stop_clock_req_n),
        .busy(),
        .done(ack_done)
    );
    cplpsc_delay #(.COUNT(GRANT_DELAY)) u_grant (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(ack_done),
        .abort(lnk.stop_clock_req_n),
        .busy(grant_busy),
        .done(grant_done)
    );
    cplpsc_delay #(.COUNT(PLL_SETTLE)) u_settle (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(state_ff == cplpsc_pkg::ST_DEEP_SLEEP && lnk.deep_sleep_req_n),
        .abort(1'b0),
        .busy(),
        .done(settle_done)
    );

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            cplpsc_pkg::ST_NORMAL: begin
                if (!lnk.stop_clock_req_n) begin
                    nxt_state = cplpsc_pkg::ST_ACK_WAIT;
                end else if (halt_exec) begin
                    nxt_state = cplpsc_pkg::ST_AUTO_HALT;
                end
            end
            cplpsc_pkg::ST_AUTO_HALT: begin
                if (wake_any) begin
                    nxt_state = cplpsc_pkg::ST_NORMAL;
                end else if (!lnk.stop_clock_req_n) begin
                    nxt_state = cplpsc_pkg::ST_ACK_WAIT;
                end else if (lnk.snoop_req) begin
                    nxt_state = cplpsc_pkg::ST_SNOOP;
                end
            end
            cplpsc_pkg::ST_ACK_WAIT, cplpsc_pkg::ST_GRANT_WAIT: begin
                if (lnk.stop_clock_req_n) begin
                    nxt_state = halt_ctx_ff ? cplpsc_pkg::ST_AUTO_HALT : cplpsc_pkg::ST_NORMAL;
                end else if (grant_done) begin
                    nxt_state = cplpsc_pkg::ST_STOP_GRANT;
                end else if (grant_busy) begin
                    nxt_state = cplpsc_pkg::ST_GRANT_WAIT;
                end
            end
            cplpsc_pkg::ST_STOP_GRANT: begin
                if (lnk.stop_clock_req_n) begin
                    nxt_state = halt_ctx_ff ? cplpsc_pkg::ST_AUTO_HALT : cplpsc_pkg::ST_NORMAL;
                end else if (!lnk.sleep_req_n) begin
                    nxt_state = cplpsc_pkg::ST_SLEEP;
                end else if (lnk.snoop_req) begin
                    nxt_state = cplpsc_pkg::ST_SNOOP;
                end
            end
            cplpsc_pkg::ST_SNOOP: begin
                if (lnk.snoop_done) begin
                    nxt_state = snp_halt_ff ?
                        cplpsc_pkg::ST_AUTO_HALT : cplpsc_pkg::ST_STOP_GRANT;
                end
            end
            cplpsc_pkg::ST_SLEEP: begin
                // snoops and interrupts ignored here
                if (!lnk.deep_sleep_req_n) begin
                    nxt_state = cplpsc_pkg::ST_DEEP_SLEEP;
                end else if (lnk.sleep_req_n) begin
                    nxt_state = cplpsc_pkg::ST_STOP_GRANT;
                end
            end
            cplpsc_pkg::ST_DEEP_SLEEP: begin
                if (lnk.deep_sleep_req_n) begin
                    nxt_state = cplpsc_pkg::ST_SETTLE;
                end
            end
            cplpsc_pkg::ST_SETTLE: begin
                if (settle_done) begin
                    nxt_state = cplpsc_pkg::ST_SLEEP;
                end
            end
            default: nxt_state = cplpsc_pkg::ST_NORMAL;
        endcase
    end

    // reset keeps stop-grant while stop-clock held, otherwise full init
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            if (state_ff == cplpsc_pkg::ST_STOP_GRANT && !lnk.stop_clock_req_n) begin
                state_ff <= cplpsc_pkg::ST_STOP_GRANT;
            end else begin
                state_ff <= cplpsc_pkg::ST_NORMAL;
            end
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            halt_ctx_ff <= 1'b0;
        end else if (state_ff == cplpsc_pkg::ST_AUTO_HALT && !lnk.stop_clock_req_n) begin
            halt_ctx_ff <= 1'b1;
        end else if (state_ff == cplpsc_pkg::ST_NORMAL) begin
            halt_ctx_ff <= 1'b0;
        end
    end

    // snoop excursion returns to the state it left
    always_ff @(posedge clk_sys) begin
        if (rst || state_ff == cplpsc_pkg::ST_STOP_GRANT) begin
            snp_halt_ff <= 1'b0;
        end else if (state_ff == cplpsc_pkg::ST_AUTO_HALT) begin
            snp_halt_ff <= 1'b1;
        end
    end

    // latching window: grant entry, grant and its snoop excursions
    logic latch_win;
    assign latch_win = state_ff == cplpsc_pkg::ST_STOP_GRANT ||
        (state_ff == cplpsc_pkg::ST_SNOOP && !snp_halt_ff) ||
        state_ff == cplpsc_pkg::ST_GRANT_WAIT;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            latched_ff <= 4'h0;
            bus_irq_ff <= 1'b0;
            svc_ff <= 4'h0;
        end else if (latch_win) begin
            latched_ff <= latched_ff | irq_now;
            bus_irq_ff <= bus_irq_ff | lnk.bus_irq_msg;
            svc_ff <= 4'h0;
        end else if (state_ff == cplpsc_pkg::ST_NORMAL) begin
            svc_ff <= latched_ff;
            latched_ff <= 4'h0;
            bus_irq_ff <= 1'b0;
        end else begin
            svc_ff <= 4'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_state == cplpsc_pkg::ST_ACK_WAIT &&
                state_ff != cplpsc_pkg::ST_ACK_WAIT;
        end
    end

    // pending-break ignores the interrupt-enable flag entirely
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pbe_ff <= 1'b1;
        end else begin
            pbe_ff <= !(state_ff == cplpsc_pkg::ST_STOP_GRANT &&
                ((|latched_ff) || bus_irq_ff));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            psi_ff <= 1'b1;
        end else begin
            psi_ff <= nxt_state != cplpsc_pkg::ST_DEEP_SLEEP;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dbuf_ff <= 1'b0;
            abuf_ff <= 1'b0;
        end else begin
            dbuf_ff <= !lnk.data_buf_power_n;
            abuf_ff <= !lnk.priority_agent_req_n;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            norm_ff <= state_ff != cplpsc_pkg::ST_STOP_GRANT || lnk.stop_clock_req_n;
            halted_ff <= 1'b0;
            snoop_ff <= 1'b0;
        end else begin
            norm_ff <= nxt_state == cplpsc_pkg::ST_NORMAL;
            halted_ff <= nxt_state == cplpsc_pkg::ST_AUTO_HALT;
            snoop_ff <= nxt_state == cplpsc_pkg::ST_SNOOP;
        end
    end

    assign lnk.pending_break_n = pbe_ff;
    assign lnk.power_status_n = psi_ff;
    assign lnk.stop_ack_cycle = ack_ff;
    assign irq_service = svc_ff;
    assign in_normal = norm_ff;
    assign halted = halted_ff;
    assign data_buf_en = dbuf_ff;
    assign addr_buf_en = abuf_ff;
    assign snoop_active = snoop_ff;
endmodule : cplpsc_cpu

`default_nettype wire

// *** src/cplpsc_defines.svh ***
`ifndef CPLPSC_DEFINES_SVH
`define CPLPSC_DEFINES_SVH

// stop-grant entry delay after acknowledge response phase, bus clocks
`define CPLPSC_GRANT_DELAY_CLKS 20
// least gap from sleep release to stop-clock release, bus clocks
`define CPLPSC_SLEEP_EXIT_CLKS 10
// bus clock stops this many clocks after deep-sleep entry
`define CPLPSC_CLK_STOP_CLKS 2
// settling after deep-sleep release
`define CPLPSC_PLL_SETTLE_NS 30000
`define CPLPSC_CLK_PERIOD_NS 4
`define CPLPSC_PLL_SETTLE_CLKS ((`CPLPSC_PLL_SETTLE_NS + `CPLPSC_CLK_PERIOD_NS - 1) / `CPLPSC_CLK_PERIOD_NS)
// response phase of the acknowledge cycle, clocks after issue
`define CPLPSC_ACK_RESP_CLKS 2
// width of local interrupt lines
`define CPLPSC_LINT_W 2

`endif

// *** src/cplpsc_delay.sv ***
`timescale 1ns/1ps
`default_nettype none

// one-shot down counter: done pulses once, COUNT clocks after start
module cplpsc_delay #(
    parameter int COUNT = 20
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic start,
    input wire logic abort,
    output logic busy,
    output logic done
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_ff;

    always_ff @(posedge clk_sys) begin
        if (rst || abort) begin
            cnt_ff <= '0;
        end else if (start) begin
            cnt_ff <= W'(COUNT);
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - W'(1);
        end
    end

    assign busy = (cnt_ff != '0);
    assign done = (cnt_ff == W'(1)) && !abort;
endmodule : cplpsc_delay

`default_nettype wire

// *** src/cplpsc_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface cplpsc_if;
    logic stop_clock_req_n;
    logic sleep_req_n;
    logic deep_sleep_req_n;
    logic cpu_clock_stop_n;
    logic pending_break_n;
    logic power_status_n;
    logic sys_mgmt_irq_n;
    logic init_n;
    logic [1:0] local_irq_lines;
    logic bus_irq_msg;
    logic snoop_req;
    logic snoop_done;
    logic stop_ack_cycle;
    logic data_buf_power_n;
    logic priority_agent_req_n;

    modport cpu (
        input stop_clock_req_n, sleep_req_n, deep_sleep_req_n, cpu_clock_stop_n,
        input sys_mgmt_irq_n, init_n, local_irq_lines, bus_irq_msg, snoop_req,
        input snoop_done, data_buf_power_n, priority_agent_req_n,
        output pending_break_n, power_status_n, stop_ack_cycle
    );

    modport sys (
        output stop_clock_req_n, sleep_req_n, deep_sleep_req_n, cpu_clock_stop_n,
        output sys_mgmt_irq_n, init_n, local_irq_lines, bus_irq_msg, snoop_req,
        output snoop_done, data_buf_power_n, priority_agent_req_n,
        input pending_break_n, power_status_n, stop_ack_cycle
    );
endinterface : cplpsc_if

`default_nettype wire

// *** src/cplpsc_pkg.sv ***
package cplpsc_pkg;

    typedef enum logic [3:0] {
        ST_NORMAL,
        ST_AUTO_HALT,
        ST_ACK_WAIT,
        ST_GRANT_WAIT,
        ST_STOP_GRANT,
        ST_SNOOP,
        ST_SLEEP,
        ST_DEEP_SLEEP,
        ST_SETTLE
    } cplpsc_state_type;

    typedef enum logic [2:0] {
        HS_IDLE,
        HS_STOP,
        HS_SLEEP,
        HS_DEEP,
        HS_DEEP_EXIT,
        HS_SLEEP_EXIT,
        HS_RELEASE
    } cplpsc_host_state_type;

endpackage : cplpsc_pkg

// *** src/cplpsc_sys.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cplpsc_defines.svh"

module cplpsc_sys #(
    parameter int PLL_SETTLE = `CPLPSC_PLL_SETTLE_CLKS,
    parameter int SLEEP_EXIT = `CPLPSC_SLEEP_EXIT_CLKS,
    parameter int CLK_STOP = `CPLPSC_CLK_STOP_CLKS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // link to processor
    cplpsc_if.sys lnk,
    // user requests
    input wire logic req_stop,
    input wire logic req_sleep,
    input wire logic req_deep,
    input wire logic in_grant,
    input wire logic [3:0] irq_in,
    input wire logic bus_irq_in,
    input wire logic snoop_in,
    input wire logic snoop_fin,
    input wire logic data_active,
    input wire logic prio_active,
    output logic bclk_stop,
    output logic seq_busy
);
    cplpsc_pkg::cplpsc_host_state_type st_ff;
    logic stp_ff, slp_ff, dslp_ff, quiet;
    logic [$clog2(PLL_SETTLE + 1)-1:0] cnt_ff;
    localparam int CW = $clog2(PLL_SETTLE + 1);

    // bus inputs held static while sleeping
    assign quiet = st_ff == cplpsc_pkg::HS_SLEEP || st_ff == cplpsc_pkg::HS_DEEP ||
        st_ff == cplpsc_pkg::HS_DEEP_EXIT || st_ff == cplpsc_pkg::HS_SLEEP_EXIT;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_ff <= cplpsc_pkg::HS_IDLE;
            stp_ff <= 1'b1;
            slp_ff <= 1'b1;
            dslp_ff <= 1'b1;
            cnt_ff <= '0;
        end else begin
            if (cnt_ff != '0) begin
                cnt_ff <= cnt_ff - CW'(1);
            end
            unique case (st_ff)
                cplpsc_pkg::HS_IDLE: if (req_stop) begin
                    stp_ff <= 1'b0;
                    st_ff <= cplpsc_pkg::HS_STOP;
                end
                cplpsc_pkg::HS_STOP: begin
                    if (!req_stop) begin
                        stp_ff <= 1'b1;
                        st_ff <= cplpsc_pkg::HS_IDLE;
                    end else if (req_sleep && in_grant) begin
                        slp_ff <= 1'b0;
                        st_ff <= cplpsc_pkg::HS_SLEEP;
                    end
                end
                cplpsc_pkg::HS_SLEEP: begin
                    if (req_deep) begin
                        dslp_ff <= 1'b0;
                        cnt_ff <= CW'(CLK_STOP);
                        st_ff <= cplpsc_pkg::HS_DEEP;
                    end else if (!req_sleep) begin
                        slp_ff <= 1'b1;
                        cnt_ff <= CW'(SLEEP_EXIT);
                        st_ff <= cplpsc_pkg::HS_SLEEP_EXIT;
                    end
                end
                cplpsc_pkg::HS_DEEP: if (!req_deep && cnt_ff == '0) begin
                    dslp_ff <= 1'b1;
                    cnt_ff <= CW'(PLL_SETTLE);
                    st_ff <= cplpsc_pkg::HS_DEEP_EXIT;
                end
                cplpsc_pkg::HS_DEEP_EXIT: if (cnt_ff == '0) begin
                    st_ff <= cplpsc_pkg::HS_SLEEP;
                end
                cplpsc_pkg::HS_SLEEP_EXIT: if (cnt_ff == '0) begin
                    st_ff <= cplpsc_pkg::HS_RELEASE;
                end
                cplpsc_pkg::HS_RELEASE: begin
                    st_ff <= cplpsc_pkg::HS_STOP;
                end
                default: st_ff <= cplpsc_pkg::HS_IDLE;
            endcase
        end
    end

    assign lnk.stop_clock_req_n = stp_ff;
    assign lnk.sleep_req_n = slp_ff;
    assign lnk.deep_sleep_req_n = dslp_ff;
    assign lnk.cpu_clock_stop_n = dslp_ff;
    assign lnk.sys_mgmt_irq_n = quiet ? 1'b1 : !irq_in[3];
    assign lnk.init_n = quiet ? 1'b1 : !irq_in[2];
    assign lnk.local_irq_lines = quiet ? 2'h0 : irq_in[1:0];
    assign lnk.bus_irq_msg = !quiet && bus_irq_in;
    assign lnk.snoop_req = !quiet && snoop_in;
    assign lnk.snoop_done = !quiet && snoop_fin;
    assign lnk.data_buf_power_n = quiet ? 1'b1 : !data_active;
    assign lnk.priority_agent_req_n = quiet ? 1'b1 : !prio_active;
    assign bclk_stop = st_ff == cplpsc_pkg::HS_DEEP && cnt_ff == '0;
    assign seq_busy = st_ff != cplpsc_pkg::HS_IDLE && st_ff != cplpsc_pkg::HS_STOP;
endmodule : cplpsc_sys

`default_nettype wire
